// ### logic/acc_pkg.sv
// Package: register map, field layout, reset values, states and timing of the calibration control
package acc_pkg;

    // ************************************************************
    // Bus geometry
    // ************************************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [7:0] OFF_CAL_ENABLE  = 8'h61;
    localparam logic [7:0] OFF_CALIBRATION_CONFIG_ZERO    = 8'h62;
    localparam logic [7:0] OFF_CALIBRATION_CONFIG_ONE    = 8'h65;
    localparam logic [7:0] OFF_CAL_STATUS  = 8'h6A;
    localparam logic [7:0] OFF_IRQ_STATUS  = 8'h70;
    localparam logic [7:0] OFF_IRQ_MASK    = 8'h71;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0] RST_CAL_ENABLE = 8'h01;
    localparam logic [7:0] RST_CALIBRATION_CONFIG_ZERO   = 8'h01;
    localparam logic [7:0] RST_CALIBRATION_CONFIG_ONE   = 8'h01;
    localparam logic [2:0] RST_IRQ_MASK   = 3'h0;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int BIT_RUN_ENABLE  = 0; // calibration_enable
    localparam int BIT_BG_OFFSET   = 3; // calibration_config_zero
    localparam int BIT_FG_OFFSET   = 2;
    localparam int BIT_BG_CAL      = 1;
    localparam int BIT_FG_CAL      = 0;
    localparam int BIT_OFFSET_REF  = 2; // calibration_config_one
    localparam int BIT_FG_COMPLETE = 0; // status
    localparam int BIT_STOPPED     = 1;
    localparam int POS_STATE_LO    = 2;
    localparam int POS_STATE_HI    = 4;

    // ************************************************************
    // Interrupt events
    // ************************************************************
    localparam int N_EVT        = 3;
    localparam int EVT_FOREGROUND_COMPLETE_FLAG  = 0;
    localparam int EVT_BG_START = 1;
    localparam int EVT_HELD     = 2;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_PERIOD_NS  = 10;
    localparam int DIV_RST_NS     = 100; // Least divider reset after re-enable
    localparam int DIV_RST_CYCLES = (DIV_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DIV_CNT_W      = 4;

    // ************************************************************
    // Sequencer states
    // ************************************************************
    typedef enum logic [2:0] {
        ST_HOLD  = 3'b000,
        ST_CLEAR = 3'b001,
        ST_FG    = 3'b010,
        ST_BG    = 3'b011,
        ST_DONE  = 3'b100
    } acc_state_e;

endpackage

// ### logic/acc_div_reset.sv
// Divider reset stretcher: holds the clock dividers in reset while calibration is held
module acc_div_reset (
    input  wire logic core_clk,
    input  wire logic reset_n,
    input  wire logic run_enable,
    output logic      divider_reset
);

    logic [acc_pkg::DIV_CNT_W-1:0] hold_cnt;

    // Count restarts whenever enable is low; dividers released only after the count
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            hold_cnt <= acc_pkg::DIV_CNT_W'(acc_pkg::DIV_RST_CYCLES);
        end else if (!run_enable) begin
            hold_cnt <= acc_pkg::DIV_CNT_W'(acc_pkg::DIV_RST_CYCLES);
        end else if (hold_cnt != '0) begin
            hold_cnt <= hold_cnt - 1'b1;
        end
    end

    // Registered so the divider reset never glitches on a bus write
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            divider_reset <= 1'b1;
        end else begin
            divider_reset <= !run_enable || (hold_cnt > 1);
        end
    end

endmodule // acc_div_reset

// ### logic/acc_irq.sv
// Interrupt block: sticky event bits, write-one-to-clear, mask and one level output
module acc_irq (
    input  wire logic                      core_clk,
    input  wire logic                      reset_n,
    input  wire logic [acc_pkg::N_EVT-1:0] evt,
    input  wire logic                      clr_wr,
    input  wire logic                      mask_wr,
    input  wire logic [acc_pkg::N_EVT-1:0] wdata,
    output logic      [acc_pkg::N_EVT-1:0] status,
    output logic      [acc_pkg::N_EVT-1:0] mask,
    output logic                           irq
);

    // Sticky bits; a new event in the clearing cycle wins over the clear
    for (genvar i = 0; i < acc_pkg::N_EVT; i++) begin : g_sticky
        always_ff @(posedge core_clk or negedge reset_n) begin
            if (!reset_n) begin
                status[i] <= 1'b0;
            end else begin
                status[i] <= evt[i] | (status[i] & !(clr_wr & wdata[i]));
            end
        end
    end

    // Mask register, one enables the matching event onto the line
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            mask <= acc_pkg::RST_IRQ_MASK;
        end else if (mask_wr) begin
            mask <= wdata;
        end
    end

    // Level output
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status & mask);
        end
    end

endmodule // acc_irq

// ### logic/acc_cal_ctrl.sv
// Calibration control: registers, sequencer and engine controls of the converter calibration
//
// Chosen here: the plain strobed port.
module acc_cal_ctrl (
    input  wire logic                       core_clk,
    input  wire logic                       reset_n,
    input  wire logic [acc_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [acc_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    output logic      [acc_pkg::DATA_W-1:0] reg_rdata,
    input  wire logic                       fg_cal_finished,
    output logic                            cal_engine_hold,
    output logic                            divider_reset,
    output logic                            cal_values_clear,
    output logic                            fg_cal_run,
    output logic                            fg_offset_cal_run,
    output logic                            bg_cal_run,
    output logic                            bg_offset_cal_run,
    output logic                            offset_ref_spare,
    output logic                            offset_ref_midcode,
    output logic                            foreground_complete_flag,
    output logic                            irq
);

    // ************************************************************
    // Address decode
    // ************************************************************

    // Shared by write and read paths
    function automatic logic reg_hit(input logic [acc_pkg::ADDR_W-1:0] addr,
                                     input logic [acc_pkg::ADDR_W-1:0] offset);
        reg_hit = (addr == offset);
    endfunction

    logic wr_enable;
    logic wr_cfg0;
    logic wr_cfg1;
    logic wr_irq_status;
    logic wr_irq_mask;

    // Write strobes per register
    assign wr_enable     = reg_wr && reg_hit(reg_addr, acc_pkg::OFF_CAL_ENABLE);
    assign wr_cfg0       = reg_wr && reg_hit(reg_addr, acc_pkg::OFF_CALIBRATION_CONFIG_ZERO);
    assign wr_cfg1       = reg_wr && reg_hit(reg_addr, acc_pkg::OFF_CALIBRATION_CONFIG_ONE);
    assign wr_irq_status = reg_wr && reg_hit(reg_addr, acc_pkg::OFF_IRQ_STATUS);
    assign wr_irq_mask   = reg_wr && reg_hit(reg_addr, acc_pkg::OFF_IRQ_MASK);

    // ************************************************************
    // Software registers
    // ************************************************************

    logic [acc_pkg::DATA_W-1:0] calibration_enable;
    logic [acc_pkg::DATA_W-1:0] calibration_config_zero;
    logic [acc_pkg::DATA_W-1:0] calibration_config_one;

    // Reserved bits are stored as written; software keeps them at reset values
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            calibration_enable <= acc_pkg::RST_CAL_ENABLE;
        end else if (wr_enable) begin
            calibration_enable <= reg_wdata;
        end
    end

    // Configuration zero: calibration mode selection
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            calibration_config_zero <= acc_pkg::RST_CALIBRATION_CONFIG_ZERO;
        end else if (wr_cfg0) begin
            calibration_config_zero <= reg_wdata;
        end
    end

    // Configuration one: offset reference selection
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            calibration_config_one <= acc_pkg::RST_CALIBRATION_CONFIG_ONE;
        end else if (wr_cfg1) begin
            calibration_config_one <= reg_wdata;
        end
    end

    logic run_enable;
    logic background_offset_cal_on;
    logic foreground_offset_cal_on;
    logic background_cal_on;
    logic foreground_cal_on;
    logic offset_reference_select;

    // Field extraction
    assign run_enable               = calibration_enable[acc_pkg::BIT_RUN_ENABLE];
    assign background_offset_cal_on = calibration_config_zero[acc_pkg::BIT_BG_OFFSET];
    assign foreground_offset_cal_on = calibration_config_zero[acc_pkg::BIT_FG_OFFSET];
    assign background_cal_on        = calibration_config_zero[acc_pkg::BIT_BG_CAL];
    assign foreground_cal_on        = calibration_config_zero[acc_pkg::BIT_FG_CAL];
    assign offset_reference_select  = calibration_config_one[acc_pkg::BIT_OFFSET_REF];

    // ************************************************************
    // Run-enable edge detection
    // ************************************************************

    logic run_enable_q;
    logic run_rise;
    logic run_fall;

    // Previous value resets low so the reset-default enable starts a calibration
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            run_enable_q <= 1'b0;
        end else begin
            run_enable_q <= run_enable;
        end
    end

    assign run_rise = run_enable && !run_enable_q;
    assign run_fall = !run_enable && run_enable_q;

    // ************************************************************
    // Calibration sequencer
    // ************************************************************

    acc_pkg::acc_state_e state;
    acc_pkg::acc_state_e next_state;

    // Next state; clearing run-enable aborts from any state
    always_comb begin
        next_state = state;
        if (!run_enable) begin
            next_state = acc_pkg::ST_HOLD;
        end else begin
            case (state)
                acc_pkg::ST_HOLD: begin
                    if (run_rise) begin
                        next_state = acc_pkg::ST_CLEAR;
                    end
                end
                acc_pkg::ST_CLEAR: begin
                    // Values are always reset; foreground pass is optional
                    if (foreground_cal_on) begin
                        next_state = acc_pkg::ST_FG;
                    end else if (background_cal_on) begin
                        next_state = acc_pkg::ST_BG;
                    end else begin
                        next_state = acc_pkg::ST_DONE;
                    end
                end
                acc_pkg::ST_FG: begin
                    if (fg_cal_finished) begin
                        if (background_cal_on) begin
                            next_state = acc_pkg::ST_BG;
                        end else begin
                            next_state = acc_pkg::ST_DONE;
                        end
                    end
                end
                acc_pkg::ST_BG: begin
                    // Background runs until software turns it off
                    if (!background_cal_on) begin
                        next_state = acc_pkg::ST_DONE;
                    end
                end
                acc_pkg::ST_DONE: begin
                    if (background_cal_on) begin
                        next_state = acc_pkg::ST_BG;
                    end
                end
                default: begin
                    next_state = acc_pkg::ST_HOLD;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= acc_pkg::ST_HOLD;
        end else begin
            state <= next_state;
        end
    end

    // ************************************************************
    // Engine controls
    // ************************************************************

    logic foreground_complete_flag_event;
    logic bg_start_event;

    assign foreground_complete_flag_event  = (state == acc_pkg::ST_FG) && fg_cal_finished && run_enable;
    assign bg_start_event = (next_state == acc_pkg::ST_BG) && (state != acc_pkg::ST_BG);

    // Registered engine controls, decoded from next_state so they change on the same edge as the state
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            cal_engine_hold   <= 1'b1;
            cal_values_clear  <= 1'b0;
            fg_cal_run        <= 1'b0;
            fg_offset_cal_run <= 1'b0;
            bg_cal_run        <= 1'b0;
            bg_offset_cal_run <= 1'b0;
        end else begin
            cal_engine_hold   <= (next_state == acc_pkg::ST_HOLD);
            cal_values_clear  <= (next_state == acc_pkg::ST_CLEAR);
            fg_cal_run        <= (next_state == acc_pkg::ST_FG);
            // Offset passes only ride on their parent calibration
            fg_offset_cal_run <= (next_state == acc_pkg::ST_FG)
                                 && foreground_offset_cal_on;
            bg_cal_run        <= (next_state == acc_pkg::ST_BG);
            bg_offset_cal_run <= (next_state == acc_pkg::ST_BG)
                                 && background_offset_cal_on;
        end
    end

    // Offset reference; spare mode is undefined without background calibration
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            offset_ref_spare   <= 1'b0;
            offset_ref_midcode <= 1'b1;
        end else begin
            offset_ref_spare   <= offset_reference_select;
            offset_ref_midcode <= !offset_reference_select;
        end
    end

    // Foreground complete: set on finish or on skip, cleared while held
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            foreground_complete_flag <= 1'b0;
        end else if (!run_enable) begin
            foreground_complete_flag <= 1'b0;
        end else if (foreground_complete_flag_event) begin
            foreground_complete_flag <= 1'b1;
        end else if ((state == acc_pkg::ST_CLEAR) && !foreground_cal_on) begin
            foreground_complete_flag <= 1'b1;
        end
    end

    // ************************************************************
    // Divider reset and interrupts
    // ************************************************************

    // Dividers follow run-enable with a minimum release delay
    acc_div_reset u_div_reset (
        .core_clk      (core_clk),
        .reset_n       (reset_n),
        .run_enable    (run_enable),
        .divider_reset (divider_reset)
    );

    logic [acc_pkg::N_EVT-1:0] irq_evt;
    logic [acc_pkg::N_EVT-1:0] irq_status;
    logic [acc_pkg::N_EVT-1:0] irq_mask;
    logic                      fg_flag_q;

    // Edge of the complete flag covers both finish and skip
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            fg_flag_q <= 1'b0;
        end else begin
            fg_flag_q <= foreground_complete_flag;
        end
    end

    always_comb begin
        irq_evt                        = '0;
        irq_evt[acc_pkg::EVT_FOREGROUND_COMPLETE_FLAG]  = foreground_complete_flag && !fg_flag_q;
        irq_evt[acc_pkg::EVT_BG_START] = bg_start_event;
        irq_evt[acc_pkg::EVT_HELD]     = run_fall;
    end

    acc_irq u_irq (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .evt      (irq_evt),
        .clr_wr   (wr_irq_status),
        .mask_wr  (wr_irq_mask),
        .wdata    (reg_wdata[acc_pkg::N_EVT-1:0]),
        .status   (irq_status),
        .mask     (irq_mask),
        .irq      (irq)
    );

    // ************************************************************
    // Read path
    // ************************************************************

    logic [acc_pkg::DATA_W-1:0] cal_status;

    // Status view: flag, stopped indication and sequencer state
    always_comb begin
        cal_status = '0;
        cal_status[acc_pkg::BIT_FG_COMPLETE] = foreground_complete_flag;
        cal_status[acc_pkg::BIT_STOPPED]     = (state == acc_pkg::ST_DONE);
        cal_status[acc_pkg::POS_STATE_HI:acc_pkg::POS_STATE_LO] = state;
    end

    // Read data stands only in the cycle after the strobe; unmapped reads zero
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= '0;
        end else if (!reg_rd) begin
            reg_rdata <= '0;
        end else if (reg_hit(reg_addr, acc_pkg::OFF_CAL_ENABLE)) begin
            reg_rdata <= calibration_enable;
        end else if (reg_hit(reg_addr, acc_pkg::OFF_CALIBRATION_CONFIG_ZERO)) begin
            reg_rdata <= calibration_config_zero;
        end else if (reg_hit(reg_addr, acc_pkg::OFF_CALIBRATION_CONFIG_ONE)) begin
            reg_rdata <= calibration_config_one;
        end else if (reg_hit(reg_addr, acc_pkg::OFF_CAL_STATUS)) begin
            reg_rdata <= cal_status;
        end else if (reg_hit(reg_addr, acc_pkg::OFF_IRQ_STATUS)) begin
            reg_rdata <= {{(acc_pkg::DATA_W - acc_pkg::N_EVT){1'b0}}, irq_status};
        end else if (reg_hit(reg_addr, acc_pkg::OFF_IRQ_MASK)) begin
            reg_rdata <= {{(acc_pkg::DATA_W - acc_pkg::N_EVT){1'b0}}, irq_mask};
        end else begin
            reg_rdata <= '0;
        end
    end

endmodule // acc_cal_ctrl

// ### verification/acc_cal_ctrl_chk.sv
// Checker: port-level properties of the calibration control block
module acc_cal_ctrl_chk (
    input wire logic                       core_clk,
    input wire logic                       reset_n,
    input wire logic [acc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [acc_pkg::DATA_W-1:0] reg_wdata,
    input wire logic                       reg_wr,
    input wire logic                       reg_rd,
    input wire logic [acc_pkg::DATA_W-1:0] reg_rdata,
    input wire logic                       fg_cal_finished,
    input wire logic                       cal_engine_hold,
    input wire logic                       divider_reset,
    input wire logic                       cal_values_clear,
    input wire logic                       fg_cal_run,
    input wire logic                       fg_offset_cal_run,
    input wire logic                       bg_cal_run,
    input wire logic                       bg_offset_cal_run,
    input wire logic                       offset_ref_spare,
    input wire logic                       offset_ref_midcode,
    input wire logic                       foreground_complete_flag,
    input wire logic                       irq
);
    timeunit 1ns;
    timeprecision 1ps;

    // ************************************************************
    // Properties
    // ************************************************************
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    chk_hold_on_clear: assert property (
        reg_wr && reg_addr == acc_pkg::OFF_CAL_ENABLE && !reg_wdata[0] |->
        ##2 (cal_engine_hold && divider_reset && !fg_cal_run && !bg_cal_run))
        else $error("engine not held after run-enable cleared");
    chk_div_with_hold: assert property (cal_engine_hold |-> divider_reset)
        else $error("dividers running while engine held");
    // Dividers must stay in reset a while after the engine is released
    chk_div_stretch: assert property ($fell(cal_engine_hold) |-> divider_reset [*8])
        else $error("divider reset released too early");
    chk_fgos_needs_fg: assert property (fg_offset_cal_run |-> fg_cal_run)
        else $error("foreground offset pass without foreground pass");
    chk_bgos_needs_bg: assert property (bg_offset_cal_run |-> bg_cal_run)
        else $error("background offset pass without background pass");
    chk_ref_exclusive: assert property (offset_ref_spare != offset_ref_midcode)
        else $error("offset reference selects not complementary");
    chk_clear_first: assert property ($rose(fg_cal_run) |-> $past(cal_values_clear))
        else $error("foreground pass without value clear");
    chk_clear_pulse: assert property (cal_values_clear |=> !cal_values_clear)
        else $error("value clear longer than one cycle");
    chk_fg_finish: assert property (
        fg_cal_run && fg_cal_finished
        && !$past(reg_wr && reg_addr == acc_pkg::OFF_CAL_ENABLE && !reg_wdata[0])
        |=> !fg_cal_run && foreground_complete_flag)
        else $error("complete flag missing after foreground pass");
    chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == '0)
        else $error("read data outside read answer cycle");
endmodule // acc_cal_ctrl_chk

bind acc_cal_ctrl acc_cal_ctrl_chk acc_cal_ctrl_chk_i (
    .core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fg_cal_finished(fg_cal_finished),
    .cal_engine_hold(cal_engine_hold), .divider_reset(divider_reset),
    .cal_values_clear(cal_values_clear), .fg_cal_run(fg_cal_run),
    .fg_offset_cal_run(fg_offset_cal_run), .bg_cal_run(bg_cal_run),
    .bg_offset_cal_run(bg_offset_cal_run), .offset_ref_spare(offset_ref_spare),
    .offset_ref_midcode(offset_ref_midcode), .foreground_complete_flag(foreground_complete_flag),
    .irq(irq)
);

// ### verification/testbench.sv
// Testbench: register access, sequencing and interrupts of the calibration control
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    // ************************************************************
    // Stimulus and observation
    // ************************************************************
    logic       core_clk = 1'b0;
    logic       reset_n  = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic       fg_cal_finished = 1'b0;
    logic [7:0] reg_rdata;
    logic       hold, div, clr, fg, fgos, bg, bgos, spare, mid, flag, irq;
    logic [7:0] outs;
    int         n_errors = 0;
    int         compares = 0;

    // Packed view: hold, div, fg, fgos, bg, bgos, spare, flag
    assign outs = {hold, div, fg, fgos, bg, bgos, spare, flag};

    acc_cal_ctrl acc_cal_ctrl_i (
        .core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .fg_cal_finished(fg_cal_finished), .cal_engine_hold(hold), .divider_reset(div),
        .cal_values_clear(clr), .fg_cal_run(fg), .fg_offset_cal_run(fgos), .bg_cal_run(bg),
        .bg_offset_cal_run(bgos), .offset_ref_spare(spare), .offset_ref_midcode(mid),
        .foreground_complete_flag(flag), .irq(irq)
    );

    always #5 core_clk = ~core_clk;

    // ************************************************************
    // Bus and check tasks
    // ************************************************************
    task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    // Data is registered at the taking edge, so look just after it
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 chk("reg read", reg_rdata, exp);
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // Finish pulse is taken on the second edge; state moves on that edge
    task automatic fin;
        @(posedge core_clk);
        fg_cal_finished <= 1'b1;
        @(posedge core_clk);
        fg_cal_finished <= 1'b0;
        #1;
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_regs;
        rd(8'h61, 8'h01);
        rd(8'h62, 8'h01);
        rd(8'h65, 8'h01);
        rd(8'h71, 8'h00);
        rd(8'h00, 8'h00);
    endtask

    task automatic t_fg;
        wait_cyc(12);
        chk("outputs", outs, 8'h20);
        fin();
        chk("outputs", outs, 8'h01);
        rd(8'h6A, 8'h13);
    endtask

    task automatic t_hold;
        wr(8'h61, 8'h00);
        wait_cyc(2);
        chk("outputs", outs, 8'hC0);
        rd(8'h61, 8'h00);
    endtask

    task automatic t_cfg;
        wr(8'h62, 8'h0F);
        wr(8'h65, 8'h05);
        wr(8'h61, 8'h01);
        wait_cyc(1);
        chk("clear", {7'h00, clr}, 8'h01);
        wait_cyc(1);
        chk("outputs", outs, 8'h72);
        chk("clear", {7'h00, clr}, 8'h00);
        fin();
        chk("outputs", outs, 8'h4F);
        wait_cyc(12);
        chk("outputs", outs, 8'h0F);
        rd(8'h70, 8'h07);
        chk("irq", {7'h00, irq}, 8'h00);
        wr(8'h71, 8'h01);
        wait_cyc(2);
        chk("irq", {7'h00, irq}, 8'h01);
        wr(8'h70, 8'h01);
        wait_cyc(2);
        chk("irq", {7'h00, irq}, 8'h00);
        rd(8'h70, 8'h06);
    endtask

    // Skip path: values cleared, no foreground pass, flag still raised
    task automatic t_skip;
        wr(8'h61, 8'h00);
        // Spare reference dropped before background calibration goes off
        wr(8'h65, 8'h01);
        wr(8'h62, 8'h00);
        wr(8'h61, 8'h01);
        wait_cyc(3);
        chk("outputs", outs, 8'h41);
        chk("midcode", {7'h00, mid}, 8'h01);
        rd(8'h6A, 8'h13);
    endtask

    // ************************************************************
    // Verdict, watchdog and main sequence
    // ************************************************************
    task automatic conclude;
        if (n_errors == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Whole run needs under a hundred cycles; this leaves ample margin
    initial begin
        repeat (5000) @(posedge core_clk);
        n_errors++;
        conclude();
    end

    initial begin
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        t_regs();
        t_fg();
        t_hold();
        t_cfg();
        t_skip();
        conclude();
    end
endmodule // testbench
